// *** design/sram_host.v ***
`include "sram_host_defs.vh"

module sram_host #(
	parameter ADDR_W = 17,
	parameter DATA_W = 8,
	parameter READ_CYC = `READ_CYC,
	parameter ACCESS_CYC = `ACCESS_CYC,
	parameter STROBE_CYC = `STROBE_CYC,
	parameter WRITE_CYC = `WRITE_CYC
) (
	input wire core_clk, // 200 MHz clock
	input wire sys_rst, // Async reset, high
	input wire clk_en, // Freezes all state when low
	input wire req_valid, // Request offered
	output wire req_ready, // Request taken this cycle
	input wire req_write, // 1 write, 0 read
	input wire [ADDR_W-1:0] req_addr, // Byte address
	input wire [DATA_W-1:0] req_wdata, // Write byte
	output reg [DATA_W-1:0] rd_data_ff, // Read byte
	output reg rd_valid_ff, // One-cycle read return
	output reg wr_done_ff, // One-cycle write done
	output reg [ADDR_W-1:0] addr_ff, // Address pins
	output reg select_low_active_n_ff, // Low-active select
	output reg select_high_active_ff, // High-active select
	output reg output_enable_n_ff, // Output enable, low active
	output reg write_strobe_n_ff, // Write strobe, low active
	input wire [DATA_W-1:0] data_bus_pins_in, // Data pins in
	output reg [DATA_W-1:0] data_bus_pins_out_ff, // Data pins out
	output reg data_bus_pins_oe_ff // High while driving data
);

// ==========================================================
// States
localparam [4:0] ST_IDLE = 5'h01;
localparam [4:0] ST_RD = 5'h02;
localparam [4:0] ST_WR = 5'h04;
localparam [4:0] ST_WEND = 5'h08;
localparam [4:0] ST_REC = 5'h10;

reg [4:0] state_ff;
reg [4:0] nxt_state;
reg [7:0] cnt_ff;
reg [7:0] nxt_cnt;

// ==========================================================
// Count helpers
function integer max_of;
	input integer a;
	input integer b;
	begin
		max_of = (a > b) ? a : b;
	end
endfunction

// Counter value seen on the edge that closes a span of n cycles
function [7:0] last_of;
	input integer n;
	integer t;
	begin
		t = n - 1;
		last_of = t[7:0];
	end
endfunction

// ==========================================================
// Spans
// Write low time must also cover address set-up to write end and least pulse
localparam integer AW_CYC = `ADDR_END_CYC;
localparam integer PW_CYC = `PULSE_CYC;
localparam integer RD_SPAN = max_of(READ_CYC, ACCESS_CYC);
localparam integer WR_SPAN = max_of(max_of(STROBE_CYC, AW_CYC), PW_CYC);
localparam [7:0] RD_LAST = last_of(RD_SPAN);
localparam [7:0] WR_LAST = last_of(WR_SPAN);
localparam [7:0] REC_LAST = last_of(WRITE_CYC);

wire rd_end;
wire wr_end;
wire rec_end;

assign rd_end = (cnt_ff == RD_LAST);
assign wr_end = (cnt_ff == WR_LAST);
assign rec_end = (cnt_ff >= REC_LAST);

// ==========================================================
// Request side
// A frozen block takes nothing, so no request is lost
assign req_ready = clk_en && (state_ff == ST_IDLE);

always @* begin
	nxt_state = state_ff;
	nxt_cnt = cnt_ff;
	case (state_ff)
		ST_IDLE: begin
			nxt_cnt = 8'h00;
			if (req_valid)
				nxt_state = req_write ? ST_WR : ST_RD;
		end
		ST_RD: begin
			nxt_cnt = cnt_ff + 8'h01;
			if (rd_end)
				nxt_state = ST_IDLE;
		end
		ST_WR: begin
			nxt_cnt = cnt_ff + 8'h01;
			if (wr_end)
				nxt_state = ST_WEND;
		end
		ST_WEND: begin
			nxt_cnt = cnt_ff + 8'h01;
			nxt_state = ST_REC;
		end
		ST_REC: begin
			nxt_cnt = cnt_ff + 8'h01;
			// Recovery stretches the write to the full cycle time
			if (rec_end)
				nxt_state = ST_IDLE;
		end
		default: begin
			nxt_state = ST_IDLE;
			nxt_cnt = 8'h00;
		end
	endcase
end

// ==========================================================
// Pin sequencing
always @(posedge core_clk or posedge sys_rst) begin
	if (sys_rst) begin
		state_ff <= ST_IDLE;
		cnt_ff <= 8'h00;
		addr_ff <= {ADDR_W{1'b0}};
		select_low_active_n_ff <= 1'b1;
		select_high_active_ff <= 1'b0;
		output_enable_n_ff <= 1'b1;
		write_strobe_n_ff <= 1'b1;
		data_bus_pins_out_ff <= {DATA_W{1'b0}};
		data_bus_pins_oe_ff <= 1'b0;
	end else if (clk_en) begin
		state_ff <= nxt_state;
		cnt_ff <= nxt_cnt;
		case (state_ff)
			ST_IDLE: begin
				if (req_valid) begin
					// Address and selects in one edge: address never late
					addr_ff <= req_addr;
					select_low_active_n_ff <= 1'b0;
					select_high_active_ff <= 1'b1;
					if (req_write) begin
						output_enable_n_ff <= 1'b1;
						write_strobe_n_ff <= 1'b0;
						data_bus_pins_out_ff <= req_wdata;
						data_bus_pins_oe_ff <= 1'b1;
					end else begin
						output_enable_n_ff <= 1'b0;
						write_strobe_n_ff <= 1'b1;
					end
				end
			end
			ST_RD: begin
				// Pins let go on the same edge that takes the data
				if (rd_end) begin
					output_enable_n_ff <= 1'b1;
					select_low_active_n_ff <= 1'b1;
					select_high_active_ff <= 1'b0;
				end
			end
			ST_WR: begin
				// Strobe alone ends the write; selects and address stay put
				if (wr_end)
					write_strobe_n_ff <= 1'b1;
			end
			ST_WEND: begin
				// Selects drop one cycle after strobe, never together with it
				data_bus_pins_oe_ff <= 1'b0;
				select_low_active_n_ff <= 1'b1;
				select_high_active_ff <= 1'b0;
			end
			default: begin
				write_strobe_n_ff <= 1'b1;
			end
		endcase
	end
end

// ==========================================================
// Returns to the requester
always @(posedge core_clk or posedge sys_rst) begin
	if (sys_rst) begin
		rd_data_ff <= {DATA_W{1'b0}};
		rd_valid_ff <= 1'b0;
		wr_done_ff <= 1'b0;
	end else if (clk_en) begin
		rd_valid_ff <= 1'b0;
		wr_done_ff <= 1'b0;
		// Sample while address still held, so hold time is not relied on
		if ((state_ff == ST_RD) && rd_end) begin
			rd_data_ff <= data_bus_pins_in;
			rd_valid_ff <= 1'b1;
		end
		// Pulse once the whole write cycle has run out
		if ((state_ff == ST_REC) && rec_end)
			wr_done_ff <= 1'b1;
	end
end

endmodule

// *** design/sram_host_defs.vh ***
`ifndef SRAM_HOST_DEFS_VH
`define SRAM_HOST_DEFS_VH

// ==========================================================
// Clock and pin timing, in ns
`define CLK_PERIOD_NS 5
`define READ_CYCLE_MIN_NS 70
`define ADDR_TO_DATA_DELAY_NS 70
`define OUTPUT_ENABLE_TO_DATA_DELAY_NS 35
`define DATA_HOLD_FROM_ADDR_NS 5
`define WRITE_DATA_SETUP_NS 30
`define WRITE_DATA_HOLD_NS 0
`define ADDR_SETUP_TO_WRITE_END_NS 60
`define ADDR_SETUP_TO_WRITE_START_NS 0
`define ADDR_HOLD_AFTER_WRITE_NS 0
`define STROBE_TO_FLOAT_DELAY_NS 25
`define STROBE_PULSE_MIN_NS 50
`define WRITE_CYCLE_MIN_NS 70

// ==========================================================
// Cycle counts, least times rounded up
`define CYC_UP(ns) (((ns) + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define READ_CYC `CYC_UP(`READ_CYCLE_MIN_NS)
`define ACCESS_CYC `CYC_UP(`ADDR_TO_DATA_DELAY_NS)
`define STROBE_SUM_NS (`WRITE_DATA_SETUP_NS + `STROBE_TO_FLOAT_DELAY_NS)
`define STROBE_CYC `CYC_UP(`STROBE_SUM_NS)
`define WRITE_CYC `CYC_UP(`WRITE_CYCLE_MIN_NS)
`define ADDR_END_CYC `CYC_UP(`ADDR_SETUP_TO_WRITE_END_NS)
`define PULSE_CYC `CYC_UP(`STROBE_PULSE_MIN_NS)

`endif

// *** test/sram_host_props.sv ***
module sram_host_props (
	input wire core_clk, // Clock
	input wire sys_rst, // Reset
	input wire clk_en, // Clock enable
	input wire rd_valid_ff, // Read return
	input wire wr_done_ff, // Write done
	input wire [16:0] addr_ff, // Address pins
	input wire select_low_active_n_ff, // Select low
	input wire select_high_active_ff, // Select high
	input wire output_enable_n_ff, // Output enable
	input wire write_strobe_n_ff, // Write strobe
	input wire data_bus_pins_oe_ff // Host drives data
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking @(posedge core_clk); endclocking
	default disable iff (sys_rst || !clk_en);
	wire wr = !write_strobe_n_ff;
	sequence s_wr_start;
		$fell(write_strobe_n_ff);
	endsequence
	// Twelve samples low: 60 ns from the start edge to the end edge
	sequence s_wr_hold;
		wr [*8] ##1 wr [*4];
	endsequence
	chk_we_read: assert property (!output_enable_n_ff |-> !wr) else $error("strobe low in read");
	chk_oe_write: assert property (wr |-> output_enable_n_ff && data_bus_pins_oe_ff) else $error("bus clash");
	chk_sel_write: assert property (wr |-> !select_low_active_n_ff && select_high_active_ff) else $error("unsel");
	chk_pulse_len: assert property (s_wr_start |-> s_wr_hold) else $error("strobe short");
	chk_addr_hold: assert property (wr && $past(wr) |-> $stable(addr_ff)) else $error("addr moved");
	chk_late_desel: assert property ($rose(write_strobe_n_ff) |-> !select_low_active_n_ff) else $error("desel");
	chk_read_ans: assert property ($fell(output_enable_n_ff) |-> ##[13:15] rd_valid_ff) else $error("no read");
	chk_read_wait: assert property (rd_valid_ff |-> !$past(output_enable_n_ff, 14)) else $error("read early");
	chk_write_done: assert property (s_wr_start |-> ##[13:16] wr_done_ff) else $error("no done");
endmodule
bind sram_host sram_host_props u_sram_host_props (.*);

// *** test/sram_host_tb_top.sv ***
module sram_host_tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	logic core_clk = 0, sys_rst = 1, clk_en = 1, req_valid = 0, req_write = 0;
	logic [16:0] req_addr = 0;
	logic [7:0] req_wdata = 0;
	wire [7:0] rd, dout, mdq;
	wire [16:0] a;
	wire rdy, rv, wd, sl, sh, oe, we, doe;
	int err_count = 0, checked = 0, cyc = 0;
	logic [25:0] rows [6] = '{26'h200A155, 26'h3FFFFAA, 26'h000A155, 26'h1FFFFAA, 26'h200000F, 26'h000000F};
	sram_host u_sram_host (.core_clk(core_clk), .sys_rst(sys_rst), .clk_en(clk_en), .req_valid(req_valid),
		.req_ready(rdy), .req_write(req_write), .req_addr(req_addr), .req_wdata(req_wdata), .rd_data_ff(rd),
		.rd_valid_ff(rv), .wr_done_ff(wd), .addr_ff(a), .select_low_active_n_ff(sl), .select_high_active_ff(sh),
		.output_enable_n_ff(oe), .write_strobe_n_ff(we), .data_bus_pins_in(doe ? dout : mdq),
		.data_bus_pins_out_ff(dout), .data_bus_pins_oe_ff(doe));
	sram_model u_sram_model (.addr(a), .sel_n(sl), .sel(sh), .oe_n(oe), .we_n(we), .din(dout), .dq(mdq));
	initial forever #2.5 core_clk = ~core_clk;
	task print_verdict;
		if (err_count == 0 && checked > 0) $display("Finished cleanly");
		else $display("Finished with errors");
		$finish;
	endtask
	task chk(input string n, input [7:0] e, input [7:0] s);
		checked++;
		if (e !== s) begin
			err_count++;
			$display("FAIL %s exp %h got %h", n, e, s);
		end
	endtask
	task offer(input [25:0] r);
		{req_write, req_addr, req_wdata} = r;
		req_valid = 1;
		do @(posedge core_clk); while (!rdy);
		#1 req_valid = 0;
	endtask
	task finish_xfer;
		int n;
		n = 0;
		while (!(rv | wd) && n < 40) begin
			@(posedge core_clk);
			#1 n++;
		end
		chk("done", 8'h01, {7'h00, rv | wd});
	endtask
	task go(input [25:0] r);
		offer(r);
		finish_xfer;
	endtask
	// Hang guard well above all nine transfers
	always @(posedge core_clk) if (++cyc == 3000) begin
		err_count++;
		print_verdict;
	end
	initial begin
		repeat (16) @(posedge core_clk);
		chk("sel_n", 8'h01, sl);
		chk("we_n", 8'h01, we);
		#1 sys_rst = 0;
		foreach (rows[i]) begin
			go(rows[i]);
			if (!rows[i][25]) chk("rd", rows[i][7:0], rd);
		end
		// Freeze mid-read: pins and count hold, the read still lands
		offer(26'h000A155);
		repeat (4) @(posedge core_clk);
		#1 chk("busy_rdy", 8'h00, rdy);
		clk_en = 0;
		repeat (20) @(posedge core_clk);
		#1 chk("frz_oe_n", 8'h00, oe);
		chk("frz_rv", 8'h00, rv);
		clk_en = 1;
		finish_xfer;
		chk("frz_rd", 8'h55, rd);
		// Reset in mid-write: pins drop to idle at once, reads still work
		offer(26'h2012334);
		repeat (4) @(posedge core_clk);
		#1 sys_rst = 1;
		@(posedge core_clk);
		#1 chk("rst_sel_n", 8'h01, sl);
		chk("rst_we_n", 8'h01, we);
		chk("rst_doe", 8'h00, doe);
		sys_rst = 0;
		go(rows[3]);
		chk("rst_rd", 8'hAA, rd);
		print_verdict;
	end
endmodule

// *** test/sram_model.sv ***
module sram_model (
	input wire [16:0] addr, // Address pins
	input wire sel_n, // Low-active select
	input wire sel, // High-active select
	input wire oe_n, // Output enable
	input wire we_n, // Write strobe
	input wire [7:0] din, // Host data
	output wire [7:0] dq // Device data
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [7:0] mem [0:131071];
	wire act = !sel_n && sel;
	wire wr = act && !we_n;
	// Store on the first edge ending the overlap
	always @(negedge wr) mem[addr] <= din;
	// Undriven bus shows the inverse, never a stale match
	assign dq = act && !oe_n && we_n ? mem[addr] : ~din;
endmodule
